// [verilog/reset_state_pkg.sv]
package reset_state_pkg;

    // ****************************************
    // port indices and widths
    // ****************************************
    localparam int NUM_PORTS = 8;
    localparam int PORT_W = 8;
    localparam logic [2:0] PORT_A = 3'h0;
    localparam logic [2:0] PORT_B = 3'h1;
    localparam logic [2:0] PORT_C = 3'h2;
    localparam logic [2:0] PORT_D = 3'h3;
    localparam logic [2:0] PORT_E = 3'h4;
    localparam logic [2:0] PORT_F = 3'h5;
    localparam logic [2:0] PORT_G = 3'h6;
    localparam logic [2:0] PORT_L = 3'h7;
    localparam int G_BIT_ZERO = 0;
    localparam int G_BIT_ONE = 1;
    localparam int G_BIT_TWO = 2;

    // ****************************************
    // values taken on initialization
    // ****************************************
    localparam logic [7:0] PORT_FLOAT = 8'h00;
    localparam logic [7:0] PORT_D_HIGH = 8'hFF;
    localparam logic [7:0] G_PULLUP_MASK = 8'h05;
    localparam logic [7:0] WDOG_BIT_MASK = 8'h02;
    localparam logic [7:0] CTRL_CLEAR = 8'h00;
    localparam logic [7:0] SP_RESET = 8'h6F;
    localparam logic [14:0] PC_RESET = 15'h0000;
    localparam logic [7:0] SIO_POWER_ON = 8'h00;
    // idle levels of the reset sources: pin high, brownout quiet
    localparam logic [1:0] SRC_IDLE = 2'h1;
    localparam int SRC_PIN = 0;
    localparam int SRC_BROWNOUT = 1;

    typedef enum logic [3:0] {
        SEL_PSW,
        SEL_MAIN_CTRL,
        SEL_INT_CTRL,
        SEL_TIMER_TWO,
        SEL_TIMER_THREE,
        SEL_HS_CONFIG,
        SEL_SERIAL,
        SEL_STACK,
        SEL_PC
    } reg_sel_t;

endpackage

// [verilog/init_req_if.sv]
interface init_req_if;
    logic init_req;
    logic pin_low;
    logic brownout;

    modport src (
        output init_req,
        output pin_low,
        output brownout
    );

    modport dst (
        input init_req,
        input pin_low,
        input brownout
    );
endinterface

// [verilog/reset_source_sync.sv]
module reset_source_sync (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reset_pin_n,
    input wire logic i_brownout,
    init_req_if.src o_req
);

    logic [1:0] raw;
    logic [1:0] s1_q;
    logic [1:0] s2_q;
    logic [1:0] s3_q;
    logic [1:0] filt_q;

    assign raw = {i_brownout, i_reset_pin_n};

    // ****************************************
    // three-stage synchronisers with agreement filter
    // ****************************************
    // a level counts only once stages two and three agree, so a one-cycle
    // glitch that reaches stage two never reaches the filtered value
    for (genvar j = 0; j < 2; j++) begin : g_src
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                s1_q[j] <= reset_state_pkg::SRC_IDLE[j];
                s2_q[j] <= reset_state_pkg::SRC_IDLE[j];
                s3_q[j] <= reset_state_pkg::SRC_IDLE[j];
                filt_q[j] <= reset_state_pkg::SRC_IDLE[j];
            end else if (i_ce) begin
                s1_q[j] <= raw[j];
                s2_q[j] <= s1_q[j];
                s3_q[j] <= s2_q[j];
                if (s2_q[j] == s3_q[j]) begin
                    filt_q[j] <= s3_q[j];
                end
            end
        end
    end

    assign o_req.pin_low = !filt_q[reset_state_pkg::SRC_PIN];
    assign o_req.brownout = filt_q[reset_state_pkg::SRC_BROWNOUT];
    assign o_req.init_req = !filt_q[reset_state_pkg::SRC_PIN] || filt_q[reset_state_pkg::SRC_BROWNOUT];

endmodule

// [verilog/reset_state_initializer.sv]
// Behaviour
// - ports float, port D driven high
// - watchdog enabled: port G bit one is watchdog
// - pull-up on G bits zero, two during reset
// - status, control, timer registers cleared
// - serial shift register kept on warm reset
// - serial register loaded with 00 hex on power-on
// - reset pin low or brownout initializes
// - stack pointer loaded with 6F hex
module reset_state_initializer #(
    parameter int PC_W = 15
) (
    input wire logic i_mclk,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_reset_pin_n,
    input wire logic i_brownout,
    input wire logic i_watchdog_en,
    input wire logic i_wdog_level,
    input wire logic [63:0] i_port_oe,
    input wire logic [63:0] i_port_out,
    input wire logic [63:0] i_port_pullup,
    input wire logic i_wr_en,
    input wire reset_state_pkg::reg_sel_t i_wr_sel,
    input wire logic [15:0] i_wr_data,
    output logic o_init_active,
    output logic [63:0] o_port_oe,
    output logic [63:0] o_port_out,
    output logic [63:0] o_port_pullup,
    output logic [PC_W-1:0] o_program_counter,
    output logic [7:0] o_stack_pointer,
    output logic [7:0] o_processor_status_word,
    output logic [7:0] o_main_control_reg,
    output logic [7:0] o_interrupt_control_reg,
    output logic [7:0] o_timer_two_control_reg,
    output logic [7:0] o_timer_three_control_reg,
    output logic [7:0] o_high_speed_timer_config_reg,
    output logic [7:0] o_serial_shift_reg
);

    // the fetch address never exceeds fifteen bits, so wider counters are refused
    if (PC_W < 1 || PC_W > 15) begin : g_pc_w_check
        $error("PC_W must lie between 1 and 15");
    end

    init_req_if req_bus ();
    logic init;

    reset_source_sync u_sync (
        .i_mclk(i_mclk),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_reset_pin_n(i_reset_pin_n),
        .i_brownout(i_brownout),
        .o_req(req_bus.src)
    );

    assign init = req_bus.init_req;

    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_init_active <= 1'b1;
        end else if (i_ce) begin
            o_init_active <= init;
        end
    end

    // ****************************************
    // port pin state
    // ****************************************
    for (genvar p = 0; p < reset_state_pkg::NUM_PORTS; p++) begin : g_port
        localparam logic [7:0] INIT_DRV = (p == int'(reset_state_pkg::PORT_D)) ?
            reset_state_pkg::PORT_D_HIGH : reset_state_pkg::PORT_FLOAT;
        localparam logic [7:0] INIT_PU = (p == int'(reset_state_pkg::PORT_G)) ?
            reset_state_pkg::G_PULLUP_MASK : reset_state_pkg::PORT_FLOAT;
        localparam logic [7:0] WD_MASK = (p == int'(reset_state_pkg::PORT_G)) ?
            reset_state_pkg::WDOG_BIT_MASK : reset_state_pkg::PORT_FLOAT;
        logic [7:0] oe_d;
        logic [7:0] out_d;
        logic [7:0] pu_d;
        logic [7:0] wd;

        always_comb begin
            wd = i_watchdog_en ? WD_MASK : 8'h00;
            if (init) begin
                oe_d = INIT_DRV;
                out_d = INIT_DRV;
                // bits zero and two pulled up
                pu_d = INIT_PU;
            end else begin
                oe_d = i_port_oe[p*8 +: 8];
                out_d = i_port_out[p*8 +: 8];
                pu_d = i_port_pullup[p*8 +: 8];
            end
            // watchdog owns bit one of port G
            oe_d = (oe_d & ~wd) | wd;
            out_d = (out_d & ~wd) | (i_wdog_level ? wd : 8'h00);
            pu_d = pu_d | wd;
        end

        // the power-on reset can only load constants, so the watchdog
        // takes its pin from the first enabled edge after its release
        always_ff @(posedge i_mclk) begin
            if (!i_rst_n) begin
                o_port_oe[p*8 +: 8] <= INIT_DRV;
                o_port_out[p*8 +: 8] <= INIT_DRV;
                o_port_pullup[p*8 +: 8] <= INIT_PU;
            end else if (i_ce) begin
                o_port_oe[p*8 +: 8] <= oe_d;
                o_port_out[p*8 +: 8] <= out_d;
                o_port_pullup[p*8 +: 8] <= pu_d;
            end
        end
    end

    // ****************************************
    // core registers
    // ****************************************
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n || (i_ce && init)) begin
            o_program_counter <= reset_state_pkg::PC_RESET[PC_W-1:0];
            o_stack_pointer <= reset_state_pkg::SP_RESET;
            o_processor_status_word <= reset_state_pkg::CTRL_CLEAR;
            o_main_control_reg <= reset_state_pkg::CTRL_CLEAR;
            o_interrupt_control_reg <= reset_state_pkg::CTRL_CLEAR;
            o_timer_two_control_reg <= reset_state_pkg::CTRL_CLEAR;
            o_timer_three_control_reg <= reset_state_pkg::CTRL_CLEAR;
            o_high_speed_timer_config_reg <= reset_state_pkg::CTRL_CLEAR;
        end else if (i_ce && i_wr_en) begin
            unique case (i_wr_sel)
                reset_state_pkg::SEL_PSW: o_processor_status_word <= i_wr_data[7:0];
                reset_state_pkg::SEL_MAIN_CTRL: o_main_control_reg <= i_wr_data[7:0];
                reset_state_pkg::SEL_INT_CTRL: o_interrupt_control_reg <= i_wr_data[7:0];
                reset_state_pkg::SEL_TIMER_TWO: o_timer_two_control_reg <= i_wr_data[7:0];
                reset_state_pkg::SEL_TIMER_THREE: o_timer_three_control_reg <= i_wr_data[7:0];
                reset_state_pkg::SEL_HS_CONFIG: o_high_speed_timer_config_reg <= i_wr_data[7:0];
                reset_state_pkg::SEL_STACK: o_stack_pointer <= i_wr_data[7:0];
                reset_state_pkg::SEL_PC: o_program_counter <= i_wr_data[PC_W-1:0];
                reset_state_pkg::SEL_SERIAL: ;
                default: ;
            endcase
        end
    end

    // serial shift register: only power-on reset touches it; its value
    // then is 00 hex, and a warm reset leaves it as it was
    always_ff @(posedge i_mclk) begin
        if (!i_rst_n) begin
            o_serial_shift_reg <= reset_state_pkg::SIO_POWER_ON;
        end else if (i_ce && !init && i_wr_en && i_wr_sel == reset_state_pkg::SEL_SERIAL) begin
            o_serial_shift_reg <= i_wr_data[7:0];
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);

    logic [7:0] g_port_oe;
    logic [7:0] g_port_pu;
    logic [7:0] d_port_out;
    assign g_port_oe = o_port_oe[int'(reset_state_pkg::PORT_G)*8 +: 8];
    assign g_port_pu = o_port_pullup[int'(reset_state_pkg::PORT_G)*8 +: 8];
    assign d_port_out = o_port_out[int'(reset_state_pkg::PORT_D)*8 +: 8];

    ports_float_a: assert property ((i_ce && init) |=>
        (o_port_oe & 64'hFFFD_FFFF_00FF_FFFF) == 64'h0 && o_port_pullup[63:56] == 8'h00 &&
        o_port_pullup[47:0] == 48'h0 && g_port_oe[1] == $past(i_watchdog_en))
        else $error("port not floating during initialization");

    port_d_high_a: assert property ((i_ce && init) |=> (d_port_out == 8'hFF &&
        o_port_oe[31:24] == 8'hFF))
        else $error("port D not driven high during initialization");

    wdog_pin_a: assert property ((i_ce && i_watchdog_en) |=> (g_port_oe[1] &&
        o_port_out[49] == $past(i_wdog_level)))
        else $error("port G bit one does not carry the watchdog output");

    g_pullup_a: assert property ((i_ce && init) |=> (g_port_pu[0] && g_port_pu[2] &&
        !g_port_oe[0] && !g_port_oe[2]))
        else $error("port G bit zero or two lacks pull-up during initialization");

    pc_clear_a: assert property ((i_ce && init) |=> o_program_counter == '0)
        else $error("program counter not cleared");

    regs_clear_a: assert property ((i_ce && init) |=> (o_processor_status_word == 8'h00 &&
        o_main_control_reg == 8'h00 && o_interrupt_control_reg == 8'h00 &&
        o_timer_two_control_reg == 8'h00 && o_timer_three_control_reg == 8'h00 &&
        o_high_speed_timer_config_reg == 8'h00))
        else $error("control register not cleared");

    sio_keep_a: assert property (init |=> $stable(o_serial_shift_reg))
        else $error("serial shift register changed during warm reset");

    sp_load_a: assert property ((i_ce && init) |=> o_stack_pointer == 8'h6F)
        else $error("stack pointer not loaded");

    pin_init_a: assert property ((i_ce && !i_reset_pin_n)[*5] |=> init)
        else $error("held reset pin did not request initialization");

    brownout_init_a: assert property ((i_ce && i_brownout)[*5] |=> init)
        else $error("brownout did not request initialization");

    held_state_a: assert property (!i_ce |=> ($stable(o_port_oe) && $stable(o_program_counter)))
        else $error("state moved while clock enable low");

    pin_reset_c: cover property ((i_ce && req_bus.pin_low) ##1 (i_ce && !init));
    brownout_c: cover property (i_ce && req_bus.brownout && !req_bus.pin_low);
    wdog_reset_c: cover property (i_ce && init && i_watchdog_en);
    warm_keep_c: cover property (o_serial_shift_reg != 8'h00 ##1 init);

endmodule

// [tb/reset_state_initializer_tb_top.sv]
module reset_state_initializer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // ****************************************
    // stimulus and design instance
    // ****************************************
    logic i_mclk = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_ce = 1'b1;
    logic i_reset_pin_n = 1'b1;
    logic i_brownout = 1'b0;
    logic i_watchdog_en = 1'b0;
    logic i_wdog_level = 1'b0;
    logic [63:0] i_port_oe = 64'h0;
    logic [63:0] i_port_out = 64'h0;
    logic [63:0] i_port_pullup = 64'h0;
    logic i_wr_en = 1'b0;
    reset_state_pkg::reg_sel_t i_wr_sel = reset_state_pkg::SEL_PSW;
    logic [15:0] i_wr_data = 16'h0;
    logic o_init_active;
    logic [63:0] o_port_oe, o_port_out, o_port_pullup;
    logic [14:0] o_program_counter;
    logic [7:0] o_stack_pointer, o_processor_status_word, o_main_control_reg, o_interrupt_control_reg;
    logic [7:0] o_timer_two_control_reg, o_timer_three_control_reg, o_high_speed_timer_config_reg;
    logic [7:0] o_serial_shift_reg;
    int errors = 0;
    int check_count = 0;
    // watchdog bit of port g inside the packed port vectors
    localparam logic [63:0] WD_BIT_M = 64'h0002000000000000;

    always #5 i_mclk = ~i_mclk;

    reset_state_initializer #(.PC_W(15)) uut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(i_ce), .i_reset_pin_n(i_reset_pin_n),
        .i_brownout(i_brownout), .i_watchdog_en(i_watchdog_en), .i_wdog_level(i_wdog_level),
        .i_port_oe(i_port_oe), .i_port_out(i_port_out), .i_port_pullup(i_port_pullup),
        .i_wr_en(i_wr_en), .i_wr_sel(i_wr_sel), .i_wr_data(i_wr_data), .o_init_active(o_init_active),
        .o_port_oe(o_port_oe), .o_port_out(o_port_out), .o_port_pullup(o_port_pullup),
        .o_program_counter(o_program_counter), .o_stack_pointer(o_stack_pointer),
        .o_processor_status_word(o_processor_status_word), .o_main_control_reg(o_main_control_reg),
        .o_interrupt_control_reg(o_interrupt_control_reg), .o_timer_two_control_reg(o_timer_two_control_reg),
        .o_timer_three_control_reg(o_timer_three_control_reg),
        .o_high_speed_timer_config_reg(o_high_speed_timer_config_reg), .o_serial_shift_reg(o_serial_shift_reg)
    );

    // ****************************************
    // access and compare tasks
    // ****************************************
    function automatic logic [15:0] reg_val(input int s);
        case (s)
            0: return {8'h00, o_processor_status_word};
            1: return {8'h00, o_main_control_reg};
            2: return {8'h00, o_interrupt_control_reg};
            3: return {8'h00, o_timer_two_control_reg};
            4: return {8'h00, o_timer_three_control_reg};
            5: return {8'h00, o_high_speed_timer_config_reg};
            6: return {8'h00, o_serial_shift_reg};
            7: return {8'h00, o_stack_pointer};
            default: return {1'b0, o_program_counter};
        endcase
    endfunction

    function automatic logic [15:0] wdata(input int s);
        return 16'h4C10 + 16'(s) * 16'h0101;
    endfunction

    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic write_one(input logic [3:0] sel, input logic [15:0] data);
        @(posedge i_mclk);
        i_wr_en <= 1'b1;
        i_wr_sel <= reset_state_pkg::reg_sel_t'(sel);
        i_wr_data <= data;
        @(posedge i_mclk);
        i_wr_en <= 1'b0;
    endtask

    // bounded wait for the init flag; sampled 1 ns after each edge
    task automatic wait_init(input logic lvl);
        int n;
        n = 0;
        #1;
        while (o_init_active !== lvl && n < 20) begin
            @(posedge i_mclk);
            #1;
            n++;
        end
        if (o_init_active !== lvl) begin
            errors++;
            $display("MISMATCH init_active expected %b seen %b", lvl, o_init_active);
            print_verdict();
        end
    endtask

    task automatic check_init(input logic wd, input logic lvl, input logic [7:0] sio);
        logic [63:0] wd_m;
        wd_m = wd ? WD_BIT_M : 64'h0;
        check("port_oe", 64'h00000000FF000000 | wd_m, o_port_oe);
        check("port_out", 64'h00000000FF000000 | ((wd & lvl) ? WD_BIT_M : 64'h0), o_port_out);
        check("port_pullup", 64'h0005000000000000 | wd_m, o_port_pullup);
        check("program_counter", 64'h0, 64'(o_program_counter));
        check("stack_pointer", 64'h6F, 64'(o_stack_pointer));
        for (int s = 0; s < 6; s++) begin
            check("control_reg", 64'h0, 64'(reg_val(s)));
        end
        check("serial_shift_reg", 64'(sio), 64'(o_serial_shift_reg));
        check("init_active", 64'h1, 64'(o_init_active));
    endtask

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (3) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        i_watchdog_en <= 1'b1;
        i_wdog_level <= 1'b1;
        i_port_oe <= 64'h0123456789ABCDEF;
        i_port_out <= 64'hFEDCBA9876543210;
        i_port_pullup <= 64'h0F0F0F0F0F0F0F0F;
        #1;
        check_init(1'b0, 1'b0, 8'h00);
        wait_init(1'b0);
        // back-to-back writes to every target, then an unknown code that must be ignored
        for (int s = 0; s < 9; s++) begin
            @(posedge i_mclk);
            i_wr_en <= 1'b1;
            i_wr_sel <= reset_state_pkg::reg_sel_t'(s[3:0]);
            i_wr_data <= wdata(s);
        end
        @(posedge i_mclk);
        i_wr_en <= 1'b0;
        write_one(4'hF, 16'h0000);
        #1;
        for (int s = 0; s < 8; s++) begin
            check("written_reg", 64'(wdata(s) & 16'h00FF), 64'(reg_val(s)));
        end
        check("program_counter", 64'(wdata(8) & 16'h7FFF), 64'(reg_val(8)));
        check("port_oe", 64'h0123456789ABCDEF | WD_BIT_M, o_port_oe);
        check("port_out", 64'hFEDCBA9876543210 | WD_BIT_M, o_port_out);
        check("port_pullup", 64'h0F0F0F0F0F0F0F0F | WD_BIT_M, o_port_pullup);
        // clock enable low: a pending write and new pin settings must wait
        @(posedge i_mclk);
        i_ce <= 1'b0;
        i_wdog_level <= 1'b0;
        i_port_out <= 64'hFFFFFFFFFFFFFFFF;
        i_wr_en <= 1'b1;
        i_wr_sel <= reset_state_pkg::SEL_PC;
        i_wr_data <= 16'h0055;
        repeat (3) @(posedge i_mclk);
        #1;
        check("port_out", 64'hFEDCBA9876543210 | WD_BIT_M, o_port_out);
        check("program_counter", 64'(wdata(8) & 16'h7FFF), 64'(o_program_counter));
        @(posedge i_mclk);
        i_ce <= 1'b1;
        i_wr_en <= 1'b0;
        @(posedge i_mclk);
        #1;
        // a low watchdog level must win over the core's high on that bit
        check("port_out", 64'hFFFFFFFFFFFFFFFF & ~WD_BIT_M, o_port_out);
        check("program_counter", 64'(wdata(8) & 16'h7FFF), 64'(o_program_counter));
        // warm reset from the pin: serial contents must survive
        @(posedge i_mclk);
        i_reset_pin_n <= 1'b0;
        i_wdog_level <= 1'b1;
        wait_init(1'b1);
        check_init(1'b1, 1'b1, 8'h16);
        write_one(4'h7, 16'h0033);
        write_one(4'h6, 16'h0044);
        #1;
        check("stack_pointer", 64'h6F, 64'(o_stack_pointer));
        check("serial_shift_reg", 64'h16, 64'(o_serial_shift_reg));
        @(posedge i_mclk);
        i_reset_pin_n <= 1'b1;
        wait_init(1'b0);
        // brownout with the watchdog option off: the watchdog bit floats like the rest
        @(posedge i_mclk);
        i_watchdog_en <= 1'b0;
        i_brownout <= 1'b1;
        wait_init(1'b1);
        check_init(1'b0, 1'b0, 8'h16);
        print_verdict();
    end
endmodule
